// ==== rct_pkg.sv ====
// Constants, field layouts and carrier types of the countdown timer block.
// Assumes a 50 MHz system clock and an AXI4-Lite register port.
package rct_pkg;
   // ==================================================================
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_T2_CNT_HI  = 8'h1c;
   localparam logic [7:0] IDX_T2_CNT_LO  = 8'h1d;
   localparam logic [7:0] IDX_T3_CTL     = 8'h1e;
   localparam logic [7:0] IDX_T3_RLD_HI  = 8'h1f;
   localparam logic [7:0] IDX_T3_RLD_LO  = 8'h20;
   localparam logic [7:0] IDX_T3_CNT_HI  = 8'h21;
   localparam logic [7:0] IDX_T3_CNT_LO  = 8'h22;
   localparam logic [7:0] IDX_WK_CTL     = 8'h23;
   localparam logic [7:0] IDX_IRQ_STAT   = 8'h28;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h29;
   localparam logic [7:0] IDX_CMD        = 8'h2a;
   // ==================================================================
   // Field positions and reset values
   localparam int         CMD_START_BIT  = 0;
   localparam int         CMD_STOP_BIT   = 1;
   localparam int         IRQ_T3_BIT     = 0;
   localparam int         IRQ_WK_BIT     = 1;
   localparam int         IRQ_W          = 2;
   localparam logic [7:0] CTL_RST        = 8'h00;
   localparam logic [7:0] RLD_RST        = 8'h00;
   localparam logic [7:0] WCTL_RST       = 8'h00;
   localparam logic [1:0] MASK_RST       = 2'h0;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;
   // ==================================================================
   // Wake-up prescaler divisors minus one, in low-frequency oscillator edges
   localparam logic [4:0] WK_DIV8_M1     = 5'h07;
   localparam logic [4:0] WK_DIV16_M1    = 5'h0f;
   localparam logic [4:0] WK_DIV32_M1    = 5'h1f;
   // ==================================================================
   // Modes and carriers
   typedef enum logic [1:0] {
      START_NONE   = 2'h0,
      START_TX_END = 2'h1,
      START_TRIM   = 2'h2,
      START_TRIM_U = 2'h3
   } rct_start_t;
   typedef enum logic [1:0] {
      CLK_13M56 = 2'h0,
      CLK_SUBC  = 2'h1,
      CLK_T0_UF = 2'h2,
      CLK_T1_UF = 2'h3
   } rct_clk_t;
   typedef struct packed {
      logic       halt_on_first_rx_nibble;
      logic       rfu6;
      rct_start_t autostart_select;
      logic       auto_reload_enable;
      logic       rfu2;
      rct_clk_t   count_clock_select;
   } rct_ctl_t;
   typedef struct packed {
      logic       wakeup_running_status;
      logic       wakeup_run_write_gate;
      logic       wakeup_auto_trim;
      logic       wakeup_auto_card_detect;
      logic       wakeup_auto_reload;
      logic       wakeup_on_underflow;
      logic [1:0] wakeup_clock_select;
   } rct_wctl_t;
endpackage

// ==== rct_down.sv ====
// Reloadable down-counter core with underflow strobe.
// Assumes start, stop and decrement strobes on the same clock.
`timescale 1ns/100ps
`default_nettype none
module rct_down #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Control
   input  wire logic         start,
   input  wire logic         stop,
   input  wire logic         dec,
   input  wire logic         uf_en,
   input  wire logic         auto_rl,
   input  wire logic [W-1:0] reload,
   // State
   output logic      [W-1:0] cnt_r,
   output logic              run_r,
   output logic              uf_r
);
   // ==================================================================
   // Counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         uf_r  <= 1'b0;
      end else begin
         uf_r <= 1'b0;
         if (start) begin
            cnt_r <= reload;
            run_r <= 1'b1;
         end else if (stop) begin
            run_r <= 1'b0;
         end else if (run_r && dec) begin
            if (cnt_r != '0) begin
               cnt_r <= cnt_r - 1'b1;
            end else if (uf_en) begin
               uf_r <= 1'b1;
               if (auto_rl) begin
                  cnt_r <= reload;
               end else begin
                  run_r <= 1'b0;
               end
            end else begin
               // Trim without underflow parks at zero, no event
               run_r <= 1'b0;
            end
         end
      end
   end
endmodule // rct_down
`default_nettype wire

// ==== rct_wake.sv ====
// Wake-up timer: prescaled low-frequency countdown with wake actions.
// Assumes lfo_s is already synchronised to aclk.
`timescale 1ns/100ps
`default_nettype none
module rct_wake #(
   parameter logic [15:0] WK_RELOAD = 16'h0100
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Oscillator level and control write
   input  wire logic              lfo_s,
   input  wire logic              wr,
   input  wire rct_pkg::rct_wctl_t wdata,
   // State and actions
   output rct_pkg::rct_wctl_t     ctl_r,
   output logic                   wake_r,
   output logic                   low_power_card_detect_r,
   output logic                   trim_r,
   output logic                   uf_r
);
   import rct_pkg::*;
   logic        lfo_d_r;
   logic [4:0]  div_r;
   logic [4:0]  div_lim;
   logic [15:0] cnt_r;
   logic        tick;
   // ==================================================================
   // Prescaler
   always_comb begin
      case (ctl_r.wakeup_clock_select)
         2'h0:    div_lim = 5'h00;
         2'h1:    div_lim = WK_DIV8_M1;
         2'h2:    div_lim = WK_DIV16_M1;
         default: div_lim = WK_DIV32_M1;
      endcase
   end
   assign tick = lfo_s && !lfo_d_r && (div_r >= div_lim);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfo_d_r <= 1'b0;
         div_r   <= 5'h00;
      end else begin
         lfo_d_r <= lfo_s;
         if (tick) begin
            div_r <= 5'h00;
         end else if (lfo_s && !lfo_d_r) begin
            div_r <= div_r + 5'h01;
         end
      end
   end
   // ==================================================================
   // Control and countdown
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_r  <= WCTL_RST;
         cnt_r  <= 16'h0000;
         wake_r <= 1'b0;
         low_power_card_detect_r <= 1'b0;
         trim_r <= 1'b0;
         uf_r   <= 1'b0;
      end else begin
         wake_r <= 1'b0;
         low_power_card_detect_r <= 1'b0;
         trim_r <= 1'b0;
         uf_r   <= 1'b0;
         if (wr) begin
            ctl_r[5:0] <= wdata[5:0];
            if (wdata.wakeup_run_write_gate) begin
               ctl_r.wakeup_running_status <= wdata.wakeup_running_status;
               cnt_r <= WK_RELOAD;
            end
         end else if (ctl_r.wakeup_running_status && tick) begin
            if (cnt_r != 16'h0000) begin
               cnt_r <= cnt_r - 16'h0001;
            end else begin
               uf_r   <= 1'b1;
               wake_r <= ctl_r.wakeup_on_underflow;
               low_power_card_detect_r <= ctl_r.wakeup_auto_card_detect;
               trim_r <= ctl_r.wakeup_auto_trim;
               cnt_r  <= WK_RELOAD;
               if (!ctl_r.wakeup_auto_reload) begin
                  ctl_r.wakeup_running_status <= 1'b0;
               end
            end
         end
      end
   end
endmodule // rct_wake
`default_nettype wire

// ==== rct_timer.sv ====
// Third general timer with wake-up timer, AXI4-Lite register slave.
// Assumes tick and underflow strobes come from logic on aclk; the trim
// and low-frequency oscillator pins are asynchronous.
//
// Summary of operation
// - Halt on first received nibble when enabled
// - Halt-on-receive ignored in trimming modes
// - Mode 00 never autostarts; 01 at transmit end
// - Trim modes start/stop on positive edge
// - Auto-reload reloads and keeps counting at zero, except in trim mode 10, which parks
// - Without auto-reload, stop at zero
// - Every underflow sets interrupt flag
// - Clock codes 00/01 pick fixed/subcarrier ticks
// - Clock codes 10/11 cascade neighbour timer underflows
// - Start loads sixteen-bit reload value
// - Reload writes wait for next start or auto-reload
// - Live count readable as two bytes
// - Second timer count readable at consecutive addresses
// - Wake-up timer wakes system, launches card detect
// - Running bit writable only with gate bit
// - Wake-up clock oscillator, direct or divided 8/16/32
`timescale 1ns/100ps
`default_nettype none
module rct_timer
   import rct_pkg::*;
#(
   parameter logic [15:0] WK_RELOAD = 16'h0100
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Link events and count ticks
   input  wire logic        tx_done,
   input  wire logic        rx_nibble,
   input  wire logic        tick_13m56,
   input  wire logic        tick_subc,
   input  wire logic        first_general_timer_uf,
   input  wire logic        second_general_timer_prev_uf,
   input  wire logic [15:0] second_timer_count,
   // Asynchronous pins
   input  wire logic        trim_edge_pin,
   input  wire logic        low_freq_oscillator,
   // Outputs
   output logic             irq,
   output logic             wakeup_req,
   output logic             low_power_card_detect,
   output logic             wakeup_trim_req
);
   import rct_pkg::*;
   // ==================================================================
   // Declarations
   rct_ctl_t          ctl_r;
   logic [7:0]        reload_value_high;
   logic [7:0]        reload_value_low;
   logic [IRQ_W-1:0]  stat_r;
   logic [IRQ_W-1:0]  mask_r;
   logic [IRQ_W-1:0]  stat_nxt;
   logic              irq_r;
   logic              have_aw_r;
   logic              have_w_r;
   logic [7:0]        wr_idx_r;
   logic              wr_hi_r;
   logic [7:0]        wdat_r;
   logic              wstb_r;
   logic              do_wr;
   logic              have_aw_nxt;
   logic              have_w_nxt;
   logic              rvalid_nxt;
   logic              wr_ok;
   logic [7:0]        rd_idx;
   logic [7:0]        rd_val;
   logic              rd_ok;
   logic              trim_m_r;
   logic              trim_s_r;
   logic              trim_d_r;
   logic              lfo_m_r;
   logic              lfo_s_r;
   logic              trim_pos;
   logic              trim_mode;
   logic [15:0]       reload_value;
   logic [15:0]       live_count;
   logic              run;
   logic              t3_uf;
   logic              wk_uf;
   logic              sw_start;
   logic              sw_stop;
   logic              start_ev;
   logic              stop_ev;
   logic              dec;
   logic              wk_wr;
   rct_wctl_t         wk_ctl;
   // ==================================================================
   // Pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trim_m_r <= 1'b0;
         trim_s_r <= 1'b0;
         trim_d_r <= 1'b0;
         lfo_m_r  <= 1'b0;
         lfo_s_r  <= 1'b0;
      end else begin
         trim_m_r <= trim_edge_pin;
         trim_s_r <= trim_m_r;
         trim_d_r <= trim_s_r;
         lfo_m_r  <= low_freq_oscillator;
         lfo_s_r  <= lfo_m_r;
      end
   end
   assign trim_pos = trim_s_r && !trim_d_r;
   // ==================================================================
   // AXI4-Lite write channel
   assign do_wr       = have_aw_r && have_w_r && !s_axi_bvalid;
   assign have_aw_nxt = do_wr ? 1'b0 :
                        (have_aw_r || (s_axi_awvalid && s_axi_awready));
   assign have_w_nxt  = do_wr ? 1'b0 :
                        (have_w_r || (s_axi_wvalid && s_axi_wready));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_aw_r     <= 1'b0;
         have_w_r      <= 1'b0;
         wr_idx_r      <= 8'h00;
         wr_hi_r       <= 1'b0;
         wdat_r        <= 8'h00;
         wstb_r        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         have_aw_r     <= have_aw_nxt;
         have_w_r      <= have_w_nxt;
         s_axi_awready <= !have_aw_nxt;
         s_axi_wready  <= !have_w_nxt;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_idx_r <= s_axi_awaddr[9:2];
            wr_hi_r  <= (s_axi_awaddr[11:10] != 2'h0);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdat_r <= s_axi_wdata[7:0];
            wstb_r <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_comb begin
      case (wr_idx_r)
         IDX_T3_CTL, IDX_T3_RLD_HI, IDX_T3_RLD_LO, IDX_WK_CTL,
         IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_CMD: wr_ok = !wr_hi_r;
         IDX_T2_CNT_HI, IDX_T2_CNT_LO,
         IDX_T3_CNT_HI, IDX_T3_CNT_LO:        wr_ok = !wr_hi_r;
         default:                             wr_ok = 1'b0;
      endcase
   end
   // Register writes
   assign wk_wr    = do_wr && wr_ok && wstb_r && (wr_idx_r == IDX_WK_CTL);
   assign sw_start = do_wr && wr_ok && wstb_r && (wr_idx_r == IDX_CMD)
                     && wdat_r[CMD_START_BIT];
   assign sw_stop  = do_wr && wr_ok && wstb_r && (wr_idx_r == IDX_CMD)
                     && wdat_r[CMD_STOP_BIT];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_r             <= CTL_RST;
         reload_value_high <= RLD_RST;
         reload_value_low  <= RLD_RST;
         mask_r            <= MASK_RST;
      end else if (do_wr && wr_ok && wstb_r) begin
         case (wr_idx_r)
            IDX_T3_CTL: begin
               ctl_r      <= wdat_r;
               ctl_r.rfu6 <= 1'b0;
               ctl_r.rfu2 <= 1'b0;
            end
            // Stored only; the counter samples it at start and at auto-reload
            IDX_T3_RLD_HI: reload_value_high <= wdat_r;
            IDX_T3_RLD_LO: reload_value_low  <= wdat_r;
            IDX_IRQ_MASK:  mask_r <= wdat_r[IRQ_W-1:0];
            default: ;
         endcase
      end
   end
   // ==================================================================
   // Interrupt status, set wins over write-one-to-clear
   always_comb begin
      stat_nxt = stat_r;
      if (do_wr && wr_ok && wstb_r && wr_idx_r == IDX_IRQ_STAT) begin
         stat_nxt = stat_nxt & ~wdat_r[IRQ_W-1:0];
      end
      stat_nxt[IRQ_T3_BIT] = stat_nxt[IRQ_T3_BIT] | t3_uf;
      stat_nxt[IRQ_WK_BIT] = stat_nxt[IRQ_WK_BIT] | wk_uf;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= '0;
         irq_r  <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         irq_r  <= |(stat_nxt & mask_r);
      end
   end
   assign irq = irq_r;
   // ==================================================================
   // AXI4-Lite read channel, byte registers in the low lane
   assign rd_idx     = s_axi_araddr[9:2];
   assign rvalid_nxt = (s_axi_arvalid && s_axi_arready) ||
                       (s_axi_rvalid && !s_axi_rready);
   always_comb begin
      rd_ok = (s_axi_araddr[11:10] == 2'h0);
      case (rd_idx)
         IDX_T2_CNT_HI: rd_val = second_timer_count[15:8];
         IDX_T2_CNT_LO: rd_val = second_timer_count[7:0];
         IDX_T3_CTL:    rd_val = ctl_r;
         IDX_T3_RLD_HI: rd_val = reload_value_high;
         IDX_T3_RLD_LO: rd_val = reload_value_low;
         IDX_T3_CNT_HI: rd_val = live_count[15:8];
         IDX_T3_CNT_LO: rd_val = live_count[7:0];
         IDX_WK_CTL:    rd_val = {wk_ctl[7], 1'b0, wk_ctl[5:0]};
         IDX_IRQ_STAT:  rd_val = {6'h00, stat_r};
         IDX_IRQ_MASK:  rd_val = {6'h00, mask_r};
         IDX_CMD:       rd_val = 8'h00;
         default: begin
            rd_val = 8'h00;
            rd_ok  = 1'b0;
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= {24'h00_0000, rd_val};
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end
   // ==================================================================
   // Start, stop and count clock selection
   assign trim_mode = ctl_r.autostart_select[1];
   assign start_ev  = sw_start ||
      (ctl_r.autostart_select == START_TX_END && tx_done) ||
      (trim_mode && trim_pos && !run);
   // Receive halt is skipped in trim modes, only the pin edge or the stop command stops
   assign stop_ev   = sw_stop ||
      (trim_mode && trim_pos && run) ||
      (!trim_mode && ctl_r.halt_on_first_rx_nibble && rx_nibble);
   always_comb begin
      case (ctl_r.count_clock_select)
         CLK_13M56: dec = tick_13m56;
         CLK_SUBC:  dec = tick_subc;
         CLK_T0_UF: dec = first_general_timer_uf;
         default:   dec = second_general_timer_prev_uf;
      endcase
   end
   assign reload_value = {reload_value_high, reload_value_low};
   rct_down #(
      .W       (16)
   ) u_down (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (start_ev),
      .stop    (stop_ev),
      .dec     (dec),
      .uf_en   (ctl_r.autostart_select != START_TRIM),
      .auto_rl (ctl_r.auto_reload_enable),
      .reload  (reload_value),
      .cnt_r   (live_count),
      .run_r   (run),
      .uf_r    (t3_uf)
   );
   // ==================================================================
   // Wake-up timer
   rct_wake #(
      .WK_RELOAD (WK_RELOAD)
   ) u_wake (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .lfo_s     (lfo_s_r),
      .wr        (wk_wr),
      .wdata     (rct_wctl_t'(wdat_r)),
      .ctl_r     (wk_ctl),
      .wake_r    (wakeup_req),
      .low_power_card_detect_r    (low_power_card_detect),
      .trim_r    (wakeup_trim_req),
      .uf_r      (wk_uf)
   );
   // ==================================================================
   // Checks
   halt_rx_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && !trim_mode && ctl_r.halt_on_first_rx_nibble && rx_nibble
      && !start_ev |=> !run)
      else $error("timer kept running after first nibble");
   trim_rx_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && trim_mode && rx_nibble && !trim_pos && !sw_stop
      && live_count > 16'h0001 |=> run)
      else $error("receive halted a trimming timer");
   autostart_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctl_r.autostart_select == START_TX_END && tx_done
      |=> run && live_count == $past(reload_value))
      else $error("no start at transmit end");
   reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
      t3_uf && ctl_r.auto_reload_enable
      |-> run && live_count == $past(reload_value))
      else $error("underflow did not reload");
   stop_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      t3_uf && !ctl_r.auto_reload_enable |-> !run && live_count == 16'h0)
      else $error("timer did not stop at zero");
   uf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      t3_uf |=> stat_r[IRQ_T3_BIT])
      else $error("underflow flag not set");
   step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && dec && live_count != 16'h0 && !start_ev && !stop_ev
      |=> live_count == $past(live_count) - 16'h0001)
      else $error("count did not step by one");
   reload_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !start_ev && !(run && dec) |=> live_count == $past(live_count))
      else $error("count moved without cause");
endmodule // rct_timer
`default_nettype wire

// ==== rct_timer_tb.sv ====
// Self-checking bench of the countdown timer, driven over AXI4-Lite.
// Assumes rct_pkg and rct_timer are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import rct_pkg::*;
   // ==========================
   // Signals
   logic        aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   // Response readies stay high, so an answer is taken at its first edge
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
   logic        s_axi_arvalid = 0, s_axi_rready = 1;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        tx_done = 0, rx_nibble = 0, tick_13m56 = 0, tick_subc = 0;
   logic        first_general_timer_uf = 0, second_general_timer_prev_uf = 0;
   logic [15:0] second_timer_count = 16'h5aa5;
   logic        trim_edge_pin = 0, low_freq_oscillator = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, irq, wakeup_req, low_power_card_detect;
   logic        wakeup_trim_req;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   int          num_errors = 0, comparisons = 0, cyc = 0;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
   num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
   rct_timer #(.WK_RELOAD(16'h0010)) uut (.*);
   always #10 aclk = ~aclk;
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   // ==========================
   // Bus cycles, each ends just after a rising edge
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      s_axi_awaddr  <= {2'h0, i, 2'h0};
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid  <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [7:0] i);
      s_axi_araddr  <= {2'h0, i, 2'h0};
      s_axi_arvalid <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   // Pin low long enough to pass the synchroniser, then a rising edge
   task automatic trim_rise();
      trim_edge_pin <= 0;
      repeat (3) @(posedge aclk);
      trim_edge_pin <= 1;
      repeat (4) @(posedge aclk);
   endtask
   // Forty oscillator periods, counting the one-cycle wake pulses
   task automatic lfo_run(output int w, output int c, output int t);
      w = 0;
      c = 0;
      t = 0;
      for (int k = 0; k < 160; k++) begin
         @(posedge aclk);
         w += wakeup_req;
         c += low_power_card_detect;
         t += wakeup_trim_req;
         if (k[0]) low_freq_oscillator <= ~low_freq_oscillator;
      end
   endtask
   // Holds the fast tick for n cycles, n decrements only while running on clock code 00
   task automatic tk(input int n);
      tick_13m56 <= 1;
      repeat (n) @(posedge aclk);
      tick_13m56 <= 0;
   endtask
   // ==========================
   // Scenarios
   task automatic t_regs();
      rdr(IDX_T3_CTL);
      `CHK(rd, 32'h0)
      wr(IDX_T3_CTL, 8'hff);
      `CHK(resp, RESP_OKAY)
      rdr(IDX_T3_CTL);
      `CHK(rd, 32'hbb)
      rdr(8'h3f);
      `CHK(resp, RESP_SLVERR)
      wr(8'h3f, 8'h01);
      `CHK(resp, RESP_SLVERR)
      rdr(IDX_T2_CNT_HI);
      `CHK(rd, 32'h5a)
      rdr(IDX_T2_CNT_LO);
      `CHK(rd, 32'ha5)
      `CHK(resp, RESP_OKAY)
   endtask
   task automatic t_reload();
      wr(IDX_T3_CTL, 8'h08);
      wr(IDX_T3_RLD_LO, 8'h03);
      wr(IDX_CMD, 8'h01);
      tk(2);
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h01)
      wr(IDX_T3_RLD_LO, 8'h09);
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h01)
      wr(IDX_T3_RLD_LO, 8'h03);
      tk(3);
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h02)
      rdr(IDX_IRQ_STAT);
      `CHK(rd, 32'h01)
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MASK, 8'h01);
      @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_STAT, 8'h01);
      `CHK(irq, 1'b0)
      wr(IDX_CMD, 8'h02);
   endtask
   // Receive halt, then a cascade count run out without reload
   task automatic t_oneshot();
      wr(IDX_T3_CTL, 8'h90);
      wr(IDX_T3_RLD_LO, 8'h05);
      tx_done <= 1;
      @(posedge aclk);
      tx_done <= 0;
      tk(1);
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h04)
      rx_nibble <= 1;
      @(posedge aclk);
      rx_nibble <= 0;
      tk(2);
      // Count read only once the receive pulse is over
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h04)
      wr(IDX_T3_CTL, 8'h02);
      wr(IDX_CMD, 8'h01);
      first_general_timer_uf <= 1;
      repeat (6) @(posedge aclk);
      first_general_timer_uf <= 0;
      tk(3);
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h00)
      rdr(IDX_IRQ_STAT);
      `CHK(rd, 32'h01)
   endtask
   // Trim modes: pin edges start and stop, receive halt has no say
   task automatic t_trim();
      wr(IDX_T3_CTL, 8'hb1);
      trim_rise();
      rx_nibble <= 1;
      @(posedge aclk);
      rx_nibble <= 0;
      tick_subc <= 1;
      @(posedge aclk);
      tick_subc <= 0;
      tk(2);
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h04)
      trim_rise();
      tick_subc <= 1;
      @(posedge aclk);
      tick_subc <= 0;
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h04)
      wr(IDX_IRQ_STAT, 8'h01);
      wr(IDX_T3_CTL, 8'h23);
      trim_rise();
      second_general_timer_prev_uf <= 1;
      repeat (7) @(posedge aclk);
      second_general_timer_prev_uf <= 0;
      rdr(IDX_T3_CNT_LO);
      `CHK(rd, 32'h00)
      rdr(IDX_IRQ_STAT);
      `CHK(rd, 32'h00)
   endtask
   // Wake-up timer: divided clock too slow to expire, direct clock fires
   task automatic t_wake();
      int w, c, t;
      wr(IDX_WK_CTL, 8'hf5);
      lfo_run(w, c, t);
      `CHK(w, 0)
      wr(IDX_WK_CTL, 8'hf4);
      lfo_run(w, c, t);
      `CHK({w[3:0], c[3:0], t[3:0]}, 12'h111)
      rdr(IDX_WK_CTL);
      `CHK(rd, 32'h34)
      wr(IDX_WK_CTL, 8'hb4);
      rdr(IDX_WK_CTL);
      `CHK(rd, 32'h34)
      rdr(IDX_IRQ_STAT);
      `CHK(rd, 32'h02)
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_reload();
      t_oneshot();
      t_trim();
      t_wake();
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
